// file: shared/result_regs_map.vh
// register offsets, field positions and reset values of the result register bank
`ifndef RESULT_REGS_MAP_VH
`define RESULT_REGS_MAP_VH

// register indices; the byte address is four times the index
`define CELL_FOURTEEN_RESULT_IDX 10'h054
`define BLOCK_RESULT_IDX 10'h055
`define SUMMED_RESULT_IDX 10'h056
`define SCAN_ENABLE_MASK_IDX 10'h05E
`define READBACK_CTRL_IDX 10'h05F

// cell and block result field: 14-bit code in bits 15:2, bits 1:0 read zero; the summed result uses all 16 bits
`define RESULT_CODE_LSB 2
`define RESULT_CODE_W 14
`define RESULT_RESET 16'h0000

// scan_enable_mask fields
`define CHAN_EN_W 14
`define BLOCK_EN_BIT 14
`define SCAN_MASK_RESET 15'h7FFF

// readback control fields
`define FILT_SEL_BIT 0
`define READBACK_CTRL_RESET 1'b0

// scan channel numbers: 0..13 are cells one to fourteen, 14 is the block
`define CELL_FOURTEEN_CHAN 4'hD
`define BLOCK_CHAN 4'hE

// summed total: cell lsb is a quarter of the total lsb
`define TOTAL_SHIFT 2
`define TOTAL_MAX 16'hFFFF

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: logic/result_hold.v
// one stored measurement result with raw and filtered copies and a registered readback word
`timescale 1ns/1ps
`include "result_regs_map.vh"

module result_hold (
	input wire aclk,
	input wire aresetn,
	input wire load,
	input wire [13:0] raw_code,
	input wire [13:0] filt_code,
	input wire filt_sel,
	output reg [15:0] rd_word
);

	reg [13:0] raw_r;
	reg [13:0] filt_r;

	// a skipped measurement never pulses load, so both copies keep their value
	always @(posedge aclk) begin
		if (!aresetn) begin
			raw_r <= 14'h0000;
			filt_r <= 14'h0000;
			rd_word <= `RESULT_RESET;
		end else begin
			if (load) begin
				raw_r <= raw_code;
				filt_r <= filt_code;
			end
			rd_word <= {(filt_sel ? filt_r : raw_r), 2'b00};
		end
	end

endmodule

// file: logic/measurement_result_registers.v
// read-only measurement result registers behind an axi4-lite slave
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "result_regs_map.vh"

module measurement_result_registers (
	input wire aclk,
	input wire aresetn,
	input wire [11:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire scan_start,
	input wire scan_done,
	input wire meas_valid,
	input wire [3:0] meas_chan,
	input wire [13:0] meas_code,
	input wire [13:0] meas_filt_code,
	input wire meas_bipolar
);

	// scan engine states
	localparam S_IDLE = 1'b0;
	localparam S_SCAN = 1'b1;

	reg [14:0] scan_enable_mask_r;
	reg filt_sel_r;
	reg aw_full_r;
	reg w_full_r;
	reg [11:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	reg state_r;
	reg state_nxt;
	reg signed [19:0] acc_r;
	reg signed [19:0] acc_nxt;
	reg [15:0] summed_result_r;
	reg [15:0] summed_nxt;
	reg meas_en;
	wire [15:0] cell_fourteen_result;
	wire [15:0] block_voltage_result;
	wire cell_fourteen_load;
	wire block_load;

	// widen a 14-bit code for the accumulator, signed when bipolar
	function signed [19:0] widen_code;
		input [13:0] code;
		input bipolar;
		begin
			if (bipolar)
				widen_code = {{6{code[13]}}, code};
			else
				widen_code = {6'h00, code};
		end
	endfunction

	// register index of a byte address
	function [9:0] reg_index;
		input [11:0] addr;
		begin
			reg_index = addr[11:2];
		end
	endfunction

	// channel enable lookup: cells from the mask low bits, block from its own bit
	always @* begin
		if (meas_chan == `BLOCK_CHAN)
			meas_en = scan_enable_mask_r[`BLOCK_EN_BIT];
		else if (meas_chan < `BLOCK_CHAN)
			meas_en = scan_enable_mask_r[meas_chan];
		else
			meas_en = 1'b0;
	end

	// a disabled channel is skipped: no load, no sum contribution
	assign cell_fourteen_load = meas_valid && meas_en && (meas_chan == `CELL_FOURTEEN_CHAN);
	assign block_load = meas_valid && meas_en && (meas_chan == `BLOCK_CHAN);

	// code held in bits 15:2 at 5 V full scale
	result_hold cell_fourteen_hold (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(cell_fourteen_load),
		.raw_code(meas_code),
		.filt_code(meas_filt_code),
		.filt_sel(filt_sel_r),
		.rd_word(cell_fourteen_result)
	);

	// block code in bits 15:2 at 65 V full scale
	result_hold block_hold (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(block_load),
		.raw_code(meas_code),
		.filt_code(meas_filt_code),
		.filt_sel(filt_sel_r),
		.rd_word(block_voltage_result)
	);

	// accumulate enabled cell results of the scan, publish at scan end
	always @* begin
		state_nxt = state_r;
		acc_nxt = acc_r;
		summed_nxt = summed_result_r;
		case (state_r)
		S_IDLE: begin
			if (scan_start) begin
				state_nxt = S_SCAN;
				acc_nxt = 20'sh00000;
			end
		end
		S_SCAN: begin
			if (meas_valid && meas_en && (meas_chan < `BLOCK_CHAN))
				acc_nxt = acc_r + widen_code(meas_code, meas_bipolar);
			if (scan_done) begin
				state_nxt = S_IDLE;
				if (acc_nxt[19]) begin
					summed_nxt = 16'h0000;
				end else if (acc_nxt[18:`TOTAL_SHIFT] > {1'b0, `TOTAL_MAX}) begin
					summed_nxt = `TOTAL_MAX;
				end else begin
					// cell lsb 5V/16384 is a quarter of the 80V/65536 total lsb
					summed_nxt = acc_nxt[17:`TOTAL_SHIFT];
				end
			end
		end
		default: begin
			state_nxt = S_IDLE;
		end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= S_IDLE;
			acc_r <= 20'sh00000;
			summed_result_r <= `RESULT_RESET;
		end else begin
			state_r <= state_nxt;
			acc_r <= acc_nxt;
			summed_result_r <= summed_nxt;
		end
	end

	// write channel: address and data taken independently, response after both
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			aw_addr_r <= 12'h000;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			scan_enable_mask_r <= `SCAN_MASK_RESET;
			filt_sel_r <= `READBACK_CTRL_RESET;
		end else begin
			s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_full_r && !s_axi_bvalid;
			s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_full_r && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (aw_full_r && w_full_r && !s_axi_bvalid) begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				case (reg_index(aw_addr_r))
				`SCAN_ENABLE_MASK_IDX: begin
					if (w_strb_r[0])
						scan_enable_mask_r[7:0] <= w_data_r[7:0];
					if (w_strb_r[1])
						scan_enable_mask_r[14:8] <= w_data_r[14:8];
				end
				`READBACK_CTRL_IDX: begin
					if (w_strb_r[0])
						filt_sel_r <= w_data_r[`FILT_SEL_BIT];
				end
				// result registers ignore writes
				`CELL_FOURTEEN_RESULT_IDX, `BLOCK_RESULT_IDX, `SUMMED_RESULT_IDX: begin
					s_axi_bresp <= `RESP_OKAY;
				end
				default: begin
					s_axi_bresp <= `RESP_SLVERR;
				end
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read channel: one read at a time, data registered with rvalid
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				case (reg_index(s_axi_araddr))
				`CELL_FOURTEEN_RESULT_IDX: s_axi_rdata <= {16'h0000, cell_fourteen_result};
				`BLOCK_RESULT_IDX: s_axi_rdata <= {16'h0000, block_voltage_result};
				`SUMMED_RESULT_IDX: s_axi_rdata <= {16'h0000, summed_result_r};
				`SCAN_ENABLE_MASK_IDX: s_axi_rdata <= {17'h00000, scan_enable_mask_r};
				`READBACK_CTRL_IDX: s_axi_rdata <= {31'h00000000, filt_sel_r};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `RESP_SLVERR;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// file: verification/mrr_properties.sv
// assertions on the axi side of the result register bank
`timescale 1ns/1ps
module mrr_properties (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready
);
	reg [11:0] addr_r;
	// address of the read now in flight
	always @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready) begin
			addr_r <= s_axi_araddr;
		end
	end
	// the slave decodes word indices, so the low address bits do not matter
	wire [9:0] idx = addr_r[11:2];
	wire res = idx == 10'h054 || idx == 10'h055;
	wire bad = idx < 10'h054 || idx > 10'h05F || (idx > 10'h056 && idx < 10'h05E);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read dropped");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("response dropped");
	a_low_bits_zero: assert property (s_axi_rvalid && res |-> s_axi_rdata[1:0] == 2'h0 && s_axi_rresp == 2'h0)
		else $error("low bits set");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper bits set");
	a_unmapped_err: assert property (s_axi_rvalid && bad |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read");
	a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready held");
	a_write_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:8] s_axi_bvalid) else $error("no bvalid");
	a_quiet_resp: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready in resp");
	c_bad_read: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	c_result_read: cover property (s_axi_rvalid && res);
	c_write_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule

// file: verification/tb.sv
// self-checking bench for the result register bank
`timescale 1ns/1ps
module tb;
	reg aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0;
	reg s_axi_rready = 1, scan_start = 0, scan_done = 0, meas_valid = 0, meas_bipolar = 0;
	reg [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	reg [31:0] s_axi_wdata = 0;
	reg [3:0] meas_chan = 0;
	reg [13:0] meas_code = 0, meas_filt_code = 0, c14 = 0, blk = 0;
	reg [15:0] tot = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	reg [33:0] q[$];
	integer fails = 0, comparisons = 0, cyc = 0;
	measurement_result_registers i_measurement_result_registers (.s_axi_awprot(3'h0), .s_axi_arprot(3'h0),
		.s_axi_wstrb(4'hF), .*);
	always #12.5 aclk = ~aclk;
	task report_and_stop;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input [33:0] seen, input [33:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	always @(posedge aclk) begin
		cyc = cyc + 1;
		if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
		if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, q.pop_front());
		if (cyc == 20000) begin
			fails = fails + 1;
			report_and_stop;
		end
	end
	task wr(input [11:0] a, input [31:0] d, input [1:0] r);
		q.push_back({r, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
	endtask
	task rd(input [11:0] a, input [33:0] e);
		q.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
	endtask
	task res3(input f);
		rd(12'h150, {18'h0, f ? ~c14 : c14, 2'h0});
		rd(12'h154, {18'h0, f ? ~blk : blk, 2'h0});
		rd(12'h158, {18'h0, tot});
	endtask
	// one scan over cells and block; filtered copy is the inverse of the raw code
	task scan(input [14:0] en, input b);
		integer i;
		reg [13:0] v;
		reg signed [31:0] s;
		s = 0;
		scan_start <= 1'b1;
		@(posedge aclk);
		scan_start <= 1'b0;
		for (i = 0; i < 15; i = i + 1) begin
			v = $urandom;
			if (b) v[13] = 1'b1;
			meas_chan <= i;
			meas_code <= v;
			meas_filt_code <= ~v;
			meas_bipolar <= b;
			meas_valid <= 1'b1;
			@(posedge aclk);
			meas_valid <= 1'b0;
			@(posedge aclk);
			if (i < 14 && en[i]) s = s + (b ? {{18{v[13]}}, v} : {18'h0, v});
			if (i == 13 && en[13]) c14 = v;
			if (i == 14 && en[14]) blk = v;
		end
		tot = s < 0 ? 16'h0000 : s[17:2];
		scan_done <= 1'b1;
		@(posedge aclk);
		scan_done <= 1'b0;
		@(posedge aclk);
	endtask
	initial begin
		void'($urandom(27962));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		res3(0);
		rd(12'h178, {2'h0, 32'h7FFF});
		rd(12'h200, {2'h2, 32'h0});
		wr(12'h150, 32'hFFFF, 2'h0);
		wr(12'h204, 32'h1, 2'h2);
		res3(0);
		$display("test reset done");
		scan(15'h7FFF, 0);
		res3(0);
		$display("test full scan done");
		wr(12'h178, 32'h1FF7, 2'h0);
		rd(12'h178, {2'h0, 32'h1FF7});
		scan(15'h1FF7, 0);
		res3(0);
		wr(12'h17C, 32'h1, 2'h0);
		res3(1);
		$display("test masked scan done");
		wr(12'h17C, 32'h0, 2'h0);
		wr(12'h178, 32'h7FFF, 2'h0);
		scan(15'h7FFF, 1);
		res3(0);
		$display("test bipolar scan done");
		// cell fourteen and block results hold nonzero codes here, so a second reset must clear them
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		c14 = 0;
		blk = 0;
		tot = 0;
		res3(0);
		$display("test second reset done");
		report_and_stop;
	end
endmodule
bind measurement_result_registers mrr_properties i_mrr_properties (.*);
